/* sthp_ctrl.sv */
// trigger dispatch, two-wire host port and instruction sequencer
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - pin 1,2,5,6 falls go to vectors 0,1,8,9
// - rises go to 4,5,12,13; power-on uses 32
// - data pin, clock pin, shared busy output
// - host mode: data low halts play, execution
// - debounced low clears receive buffer
// - eight bits, LSB first, on clock rises
// - busy rises per MSB: clock or data
// - data high starts service, busy while playing
// - mode bit 2 selects busy or stop
// - without host mode, pins trigger directly
// - one instruction per two sample periods
// - conditional instructions act only when true
// - jump, load, move, increment, end supported
// - conditions: last play, pin high, low
// - power-on, then fall/rise by pin order
// - edge acts only when enable bit set
// - debounce long 50 ms, short 400 us
// - after reset wait 160 ms, run 32
module sthp_ctrl
  import sthp_pkg::*;
#(
  parameter int unsigned POI_CYC = POI_CYC_DEF,         // power-on delay
  parameter int unsigned DEB_LONG_CYC = DEB_LONG_CYC_DEF,
  parameter int unsigned DEB_SHORT_CYC = DEB_SHORT_CYC_DEF,
  parameter int unsigned INSTR_CYC = INSTR_CYC_DEF      // at least 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic host_mode_i,
  input wire logic serial_data_trigger_pin_i,
  input wire logic serial_clock_trigger_pin_i,
  input wire logic trigger_pin_five_i,
  input wire logic trigger_pin_six_i,
  output logic [PC_W-1:0] instr_addr_o,
  input wire logic [INSTR_W-1:0] instr_data_i,
  input wire logic last_play_i,
  input wire logic play_busy_i,
  output logic play_halt_o,
  output logic stop_a_or_busy_out_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sthp_st_e st;                  // sequencer and host port state
    logic [3:0] s1;                // synchroniser, first stage
    logic [3:0] s2;                // synchroniser, second stage
    logic [3:0] stable;            // debounced pin levels
    logic [3:0][CNT_W-1:0] dcnt;   // debounce counters
    logic sclk_q;                  // clock pin, one cycle late
    logic [CNT_W-1:0] cnt;         // shared wait counter
    logic [9:0][7:0] regs;         // programmable registers
    logic [7:0] entry;             // current entry vector
    logic [STEP_W-1:0] step;       // instruction within the entry
    sthp_instr_s ins;              // instruction being timed
    logic [7:0] rx_buf;            // host receive buffer
    logic [3:0] bit_cnt;           // bits received
    logic busy;                    // busy toward the controller
    logic [7:0] rdata;             // bus read data
  } sthp_core_s;

  sthp_core_s q;                   // registered state
  sthp_core_s n;                   // next state
  logic [3:0] fall;                // debounced falling edges
  logic [3:0] rise;                // debounced rising edges
  logic trig_hit;                  // an enabled edge asks for service
  logic [7:0] trig_vec;            // vector of the winning edge
  logic start;                     // dispatch to start_vec
  logic [7:0] start_vec;
  logic cond_ok;                   // condition of q.ins holds
  logic exec_st;                   // sequencer may be interrupted
  logic sclk_rise;                 // clock pin rose
  logic host_go;                   // data pin pulled low in host mode
  logic [CNT_W-1:0] deb_lim;       // debounce length less one
  logic [3:0] en_f;
  logic [3:0] en_r;
  logic [3:0] rs;                  // general register from src
  logic [3:0] rd;                  // general register from dst

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  // pins are sampled twice before use; only s2 is read by logic
  always_comb begin
    n = q;
    n.s1 = {trigger_pin_six_i, trigger_pin_five_i,
            serial_clock_trigger_pin_i, serial_data_trigger_pin_i};
    n.s2 = q.s1;
    n.sclk_q = q.s2[1];
    n.rdata = '0;
    start = 1'b0;
    start_vec = '0;
    trig_hit = 1'b0;
    trig_vec = '0;
    rs = REG_R0 + {2'b00, q.ins.src};
    rd = REG_R0 + {2'b00, q.ins.dst[1:0]};
    sclk_rise = q.s2[1] && !q.sclk_q;
    exec_st = (q.st == ST_IDLE) || (q.st == ST_FETCH) ||
              (q.st == ST_LOAD) || (q.st == ST_WAIT);
    // only a declared host mode turns the data pin into a link
    host_go = host_mode_i && exec_st && !q.s2[0];

    // debounce: level must differ for the whole time to be taken
    deb_lim = q.regs[REG_MODE_CFG_FIRST][MODE_CFG_FIRST_DEB_LONG] ? CNT_W'(DEB_LONG_CYC - 1)
                                                : CNT_W'(DEB_SHORT_CYC - 1);
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] == q.stable[i]) begin
        n.dcnt[i] = '0;
      end else if (q.dcnt[i] >= deb_lim) begin
        n.stable[i] = q.s2[i];
        n.dcnt[i] = '0;
      end else begin
        n.dcnt[i] = q.dcnt[i] + 1'b1;
      end
    end
    fall = q.stable & ~n.stable;
    rise = ~q.stable & n.stable;

    // edge enables, in pin order
    en_f = {q.regs[REG_EN1][EN_FALL_B], q.regs[REG_EN1][EN_FALL_A],
            q.regs[REG_EN0][EN_FALL_B], q.regs[REG_EN0][EN_FALL_A]};
    en_r = {q.regs[REG_EN1][EN_RISE_B], q.regs[REG_EN1][EN_RISE_A],
            q.regs[REG_EN0][EN_RISE_B], q.regs[REG_EN0][EN_RISE_A]};
    // walk from lowest priority up so the last hit wins
    for (int i = 3; i >= 0; i--) begin
      if (rise[i] && en_r[i]) begin
        trig_hit = 1'b1;
        trig_vec = VEC_RISE[i];
      end
      if (fall[i] && en_f[i]) begin
        trig_hit = 1'b1;
        trig_vec = VEC_FALL[i];
      end
    end

    // condition test of the timed instruction
    case (q.ins.cond)
      CND_LAST: cond_ok = last_play_i;
      CND_HIGH: cond_ok = q.stable[q.ins.pin];
      CND_LOW: cond_ok = !q.stable[q.ins.pin];
      default: cond_ok = 1'b1;
    endcase

    // software register writes; an instruction in the same cycle wins
    if (reg_wr_i && reg_addr_i <= REG_R3) begin
      n.regs[reg_addr_i] = reg_wdata_i;
    end
    // reads answer in the next cycle only; unmapped reads give zero
    if (reg_rd_i) begin
      if (reg_addr_i <= REG_R3) begin
        n.rdata = q.regs[reg_addr_i];
      end else if (reg_addr_i == REG_STAT) begin
        n.rdata = {4'h0, q.st == ST_POI, !exec_st, exec_st && q.st != ST_IDLE,
                   q.busy};
      end else if (reg_addr_i == REG_RXB) begin
        n.rdata = q.rx_buf;
      end else begin
        n.rdata = '0;
      end
    end

    // sequencer and host port
    case (q.st)
      // power-on wait, then the initialisation entry
      ST_POI: begin
        if (q.cnt >= CNT_W'(POI_CYC - 1)) begin
          start = 1'b1;
          start_vec = VEC_POI;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      // pending host byte: wait for the data pin to come back
      ST_HEND: begin
        if (q.s2[0]) begin
          n.busy = 1'b1;
          start = 1'b1;
          start_vec = q.rx_buf;
        end
      end
      // low must last a debounce time; a short glitch is dropped
      ST_HDEB: begin
        if (q.s2[0]) begin
          n.st = ST_IDLE;
        end else if (q.cnt >= deb_lim) begin
          n.rx_buf = '0;
          n.bit_cnt = '0;
          n.st = ST_HRX;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      // shift in on each clock rise, first bit lands at the bottom
      ST_HRX: begin
        if (sclk_rise) begin
          n.rx_buf = {q.s2[0], q.rx_buf[7:1]};
          n.bit_cnt = q.bit_cnt + 1'b1;
          if (q.bit_cnt == 4'h7) begin
            n.st = ST_HEND;
            n.busy = q.s2[0];
          end
        end
      end
      default: begin
        if (host_go) begin
          // stop everything and listen to the controller
          n.st = ST_HDEB;
          n.cnt = '0;
        end else if (trig_hit) begin
          start = 1'b1;
          start_vec = trig_vec;
        end else begin
          case (q.st)
            ST_FETCH: n.st = ST_LOAD;
            ST_LOAD: begin
              n.ins = sthp_instr_s'(instr_data_i);
              n.cnt = '0;
              n.st = ST_WAIT;
            end
            // the instruction acts at the end of its cycle
            ST_WAIT: begin
              if (q.cnt >= CNT_W'(INSTR_CYC - 3)) begin
                n.step = q.step + 1'b1;
                n.st = ST_FETCH;
                if (cond_ok) begin
                  case (q.ins.op)
                    OP_JP_G: begin
                      start = 1'b1;
                      start_vec = q.ins.imm;
                    end
                    OP_JP_R: begin
                      start = 1'b1;
                      start_vec = q.regs[rs];
                    end
                    OP_LD: begin
                      if (q.ins.dst <= REG_R3) begin
                        n.regs[q.ins.dst] = q.ins.imm;
                      end
                    end
                    OP_MV: n.regs[rd] = q.regs[rs];
                    OP_INC: n.regs[REG_R0] = q.regs[REG_R0] + 1'b1;
                    OP_END: n.st = ST_IDLE;
                    default: n.st = ST_IDLE;
                  endcase
                end
              end else begin
                n.cnt = q.cnt + 1'b1;
              end
            end
            // busy ends once the service and its voice are over
            default: begin
              if (!play_busy_i) begin
                n.busy = 1'b0;
              end
            end
          endcase
        end
      end
    endcase

    // any accepted request restarts the sequencer at its entry
    if (start) begin
      n.entry = start_vec;
      n.step = '0;
      n.st = ST_FETCH;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // pins reset to their pulled-high level so no edge fires at release
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= ST_POI;
      q.s1 <= 4'hf;
      q.s2 <= 4'hf;
      q.stable <= 4'hf;
      q.sclk_q <= 1'b1;
      q.regs[REG_EN0] <= RST_EN;
      q.regs[REG_EN1] <= RST_EN;
      q.regs[REG_MODE_CFG_FIRST] <= RST_MODE;
      q.regs[REG_MODE1] <= RST_MODE;
      q.regs[REG_STOP] <= RST_STOP;
      q.regs[REG_PAGE] <= RST_PAGE;
      q.regs[6] <= RST_GEN;
      q.regs[7] <= RST_GEN;
      q.regs[8] <= RST_GEN;
      q.regs[9] <= RST_GEN;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign instr_addr_o = {q.regs[REG_PAGE][PAGE_W-1:0], q.entry, q.step};
  assign play_halt_o = !exec_st && (q.st != ST_POI);
  // shared pin: busy when the select bit is clear
  assign stop_a_or_busy_out_o = q.regs[REG_MODE_CFG_FIRST][MODE_CFG_FIRST_PIN_SEL] ?
                                q.regs[REG_STOP][STOP_A_BIT] : q.busy;
  assign reg_rdata_o = q.rdata;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [CNT_W-1:0] gap_q;         // cycles since the last fetch
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || q.st == ST_FETCH) begin
      gap_q <= CNT_W'(1);
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_last_bit;
    q.st == ST_HRX && sclk_rise && q.bit_cnt == 4'h7;
  endsequence
  sequence s_data_back;
    q.st == ST_HEND && q.s2[0];
  endsequence

  a_poi_entry: assert property (
    q.st == ST_POI && q.cnt >= CNT_W'(POI_CYC - 1)
    |=> q.st == ST_FETCH && q.entry == VEC_POI && q.step == '0)
    else $error("power-on entry not taken");
  a_pin1_fall: assert property (
    exec_st && !host_go && fall[0] && en_f[0] |=> q.entry == VEC_FALL[0]
    && q.st == ST_FETCH)
    else $error("falling edge of pin one not dispatched");
  a_pin6_rise: assert property (
    exec_st && !host_go && rise == 4'h8 && fall == 4'h0 && en_r[3]
    |=> q.entry == VEC_RISE[3])
    else $error("rising edge of pin six not dispatched");
  a_edge_masked: assert property (
    exec_st && q.st != ST_WAIT && !host_go && (fall & en_f) == 4'h0
    && (rise & en_r) == 4'h0 && q.st == ST_IDLE |=> q.st != ST_FETCH)
    else $error("disabled edge started service");
  a_host_halt: assert property (
    host_go |=> q.st == ST_HDEB && play_halt_o)
    else $error("low data pin did not halt");
  a_rx_clear: assert property (
    q.st == ST_HDEB ##1 q.st == ST_HRX |-> q.rx_buf == '0 && q.bit_cnt == '0)
    else $error("receive buffer not cleared");
  a_lsb_first: assert property (
    q.st == ST_HRX && sclk_rise |=> q.rx_buf[7] == $past(q.s2[0], 1))
    else $error("bit not shifted in at the top");
  a_busy_msb: assert property (
    s_last_bit |=> q.busy == q.rx_buf[7] && q.st == ST_HEND)
    else $error("busy does not follow the final bit");
  a_host_vector: assert property (
    s_data_back |=> q.busy && q.entry == $past(q.rx_buf, 1) && q.st == ST_FETCH)
    else $error("host byte not used as entry");
  a_instr_cycle: assert property (
    q.st == ST_FETCH && $past(q.st, 1) == ST_WAIT && !$past(trig_hit, 1)
    && !$past(host_go, 1) |-> gap_q == CNT_W'(INSTR_CYC))
    else $error("instruction cycle length wrong");
  a_cond_skip: assert property (
    q.st == ST_WAIT && q.cnt >= CNT_W'(INSTR_CYC - 3) && !cond_ok && !reg_wr_i
    && !trig_hit && !host_go |=> q.regs == $past(q.regs, 1) && q.st == ST_FETCH)
    else $error("false condition changed state");
  a_busy_pin: assert property (
    !q.regs[REG_MODE_CFG_FIRST][MODE_CFG_FIRST_PIN_SEL] |-> stop_a_or_busy_out_o == q.busy)
    else $error("shared pin not showing busy");

endmodule : sthp_ctrl

`default_nettype wire

/* sthp_host_mcu.sv */
// partner model: external controller on the two-wire host port
`timescale 1ns/10ps
`default_nettype none
// *****
// two-wire serial sender, 80 ns link clock
// *****
module sthp_host_mcu (
  output var logic data_o,
  output var logic clock_o
);
  localparam time HALF = 40;      // half link period
  localparam time DEB_WAIT = 600; // well past the device debounce
  // lines idle high; the clock stands still outside frames
  initial begin
    data_o = 1'b1;
    clock_o = 1'b1;
  end
  // plain levels, for use of the two pins as trigger inputs
  task automatic level(input logic d, input logic c);
    data_o <= d;
    clock_o <= c;
  endtask : level
  // pull data low, then eight bits lsb first; data ends at the msb
  task automatic send_bits(input logic [7:0] b);
    #3;
    data_o = 1'b0;
    #DEB_WAIT;
    for (int i = 0; i < 8; i++) begin
      clock_o = 1'b0;
      data_o = b[i];
      #HALF;
      clock_o = 1'b1;
      #HALF;
    end
  endtask : send_bits
  // data back high closes the frame
  task automatic release_data();
    data_o = 1'b1;
  endtask : release_data
endmodule : sthp_host_mcu
`default_nettype wire

/* sthp_pkg.sv */
// package: constants and types of the speech trigger host port
package sthp_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint unsigned CLK_HZ = 100_000_000;   // system clock rate
  localparam longint unsigned MS_PER_S = 1_000;
  localparam longint unsigned US_PER_S = 1_000_000;
  localparam longint unsigned SAMPLE_HZ = 6_000;       // voice sampling rate
  localparam longint unsigned INSTR_SAMPLES = 2;       // sample periods per instruction
  localparam longint unsigned POI_DELAY_MS = 160;      // power-on delay
  localparam longint unsigned DEB_LONG_MS = 50;        // long debounce, least
  localparam longint unsigned DEB_SHORT_US = 400;      // short debounce, least
  localparam int unsigned INSTR_CYC_DEF =
    32'((INSTR_SAMPLES * CLK_HZ + SAMPLE_HZ - 1) / SAMPLE_HZ);
  localparam int unsigned POI_CYC_DEF = 32'(POI_DELAY_MS * CLK_HZ / MS_PER_S);
  localparam int unsigned DEB_LONG_CYC_DEF =
    32'((DEB_LONG_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S);
  localparam int unsigned DEB_SHORT_CYC_DEF =
    32'((DEB_SHORT_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int CNT_W = 24;                           // wide enough for the power-on delay

  // ****************************************************************
  // entry vectors, pin order: data pin, clock pin, pin five, pin six
  // ****************************************************************
  localparam logic [3:0][7:0] VEC_FALL = {8'h09, 8'h08, 8'h01, 8'h00};
  localparam logic [3:0][7:0] VEC_RISE = {8'h0d, 8'h0c, 8'h05, 8'h04};
  localparam logic [7:0] VEC_POI = 8'h20;

  // ****************************************************************
  // register file indices and reset values
  // ****************************************************************
  localparam logic [3:0] REG_EN0 = 4'h0;   // edge_enable_first
  localparam logic [3:0] REG_EN1 = 4'h1;   // edge_enable_second
  localparam logic [3:0] REG_MODE_CFG_FIRST = 4'h2; // mode_cfg_first
  localparam logic [3:0] REG_MODE1 = 4'h3;
  localparam logic [3:0] REG_STOP = 4'h4;
  localparam logic [3:0] REG_PAGE = 4'h5;
  localparam logic [3:0] REG_R0 = 4'h6;    // general_reg_n 0..3 at 6..9
  localparam logic [3:0] REG_R3 = 4'h9;
  localparam logic [3:0] REG_STAT = 4'ha;  // read-only status
  localparam logic [3:0] REG_RXB = 4'hb;   // last received host byte
  localparam logic [7:0] RST_EN = 8'h33;
  localparam logic [7:0] RST_MODE = 8'hff;
  localparam logic [7:0] RST_STOP = 8'h1f;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_GEN = 8'h20;
  localparam int MODE_CFG_FIRST_DEB_LONG = 4;       // 1: long debounce
  localparam int MODE_CFG_FIRST_PIN_SEL = 2;        // 1: stop_a_output, 0: busy
  localparam int STOP_A_BIT = 0;
  localparam int EN_FALL_A = 0;
  localparam int EN_FALL_B = 1;
  localparam int EN_RISE_A = 4;
  localparam int EN_RISE_B = 5;
  localparam int PAGE_W = 5;
  localparam int STEP_W = 4;
  localparam int PC_W = PAGE_W + 8 + STEP_W;

  // ****************************************************************
  // instruction word
  // ****************************************************************
  localparam int INSTR_W = 24;
  typedef enum logic [3:0] {
    OP_JP_G = 4'h0, OP_JP_R = 4'h1, OP_LD = 4'h2,
    OP_MV = 4'h3, OP_INC = 4'h4, OP_END = 4'h5
  } sthp_op_e;
  typedef enum logic [1:0] {
    CND_NONE = 2'h0, CND_LAST = 2'h1, CND_HIGH = 2'h2, CND_LOW = 2'h3
  } sthp_cond_e;
  typedef struct packed {
    sthp_op_e op;      // 23:20
    sthp_cond_e cond;  // 19:18
    logic [1:0] pin;   // 17:16, pin index in pin order (2 is pin five)
    logic [3:0] dst;   // 15:12
    logic [1:0] src;   // 11:10
    logic [1:0] rsvd;  // 9:8
    logic [7:0] imm;   // 7:0
  } sthp_instr_s;

  typedef enum logic [2:0] {
    ST_POI, ST_IDLE, ST_FETCH, ST_LOAD, ST_WAIT, ST_HDEB, ST_HRX, ST_HEND
  } sthp_st_e;

endpackage : sthp_pkg

/* tb_sthp_ctrl.sv */
// testbench of the trigger dispatch and host port block
`timescale 1ns/10ps
`default_nettype none
// *****
// bench top
// *****
module tb_sthp_ctrl;
  import sthp_pkg::*;
  localparam int unsigned POI_T = 200;  // shortened power-on wait
  localparam int unsigned INSTR_T = 8;  // shortened instruction cycle
  localparam logic [7:0] FALL [4] = '{8'h00, 8'h01, 8'h08, 8'h09};
  localparam logic [7:0] RISE [4] = '{8'h04, 8'h05, 8'h0c, 8'h0d};
  localparam logic [3:0] RA [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hc};
  localparam logic [7:0] RV [9] = '{8'h33, 8'h33, 8'hff, 8'hff, 8'h1f, 8'h00, 8'h20, 8'h20, 8'h00};
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic host_mode_i = 1'b0;
  logic trigger_pin_five_i = 1'b1;
  logic trigger_pin_six_i = 1'b1;
  logic last_play_i = 1'b0; // keeps the last-play condition false
  logic play_busy_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [INSTR_W-1:0] instr_data_i = '0;
  logic [PC_W-1:0] instr_addr_o;
  logic play_halt_o;
  logic stop_a_or_busy_out_o;
  logic [7:0] reg_rdata_o;
  wire sdata_w;
  wire sclk_w;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;

  // *****
  // program memory, synchronous read
  // *****
  function automatic logic [INSTR_W-1:0] rom(input logic [PC_W-1:0] a);
    sthp_instr_s w;
    w = '{op: OP_END, cond: CND_NONE, pin: 2'h0, dst: 4'h0, src: 2'h0, rsvd: 2'h0, imm: 8'h00};
    case (a[11:0]) // end everywhere else, vector 255 too
      12'h200: begin w.op = OP_LD; w.dst = REG_MODE_CFG_FIRST; w.imm = 8'heb; end // busy, short
      12'h201: begin w.op = OP_LD; w.dst = REG_EN0; w.imm = 8'h00; end
      12'h220: begin w.op = OP_INC; w.cond = CND_LAST; end // skipped
      12'h221: begin w.op = OP_INC; w.cond = CND_HIGH; w.pin = 2'h2; end // acts
      12'h222: begin w.op = OP_INC; w.cond = CND_LOW; w.pin = 2'h2; end // skipped
      default: ;
    endcase
    return w;
  endfunction : rom
  always @(posedge clk_sys_i) instr_data_i <= rom(instr_addr_o);

  sthp_ctrl #(.POI_CYC(POI_T), .DEB_LONG_CYC(60), .DEB_SHORT_CYC(20), .INSTR_CYC(INSTR_T))
  sthp_ctrl_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .host_mode_i(host_mode_i),
    .serial_data_trigger_pin_i(sdata_w), .serial_clock_trigger_pin_i(sclk_w),
    .trigger_pin_five_i(trigger_pin_five_i), .trigger_pin_six_i(trigger_pin_six_i),
    .instr_addr_o(instr_addr_o), .instr_data_i(instr_data_i), .last_play_i(last_play_i),
    .play_busy_i(play_busy_i), .play_halt_o(play_halt_o),
    .stop_a_or_busy_out_o(stop_a_or_busy_out_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
  sthp_host_mcu sthp_host_mcu_inst (.data_o(sdata_w), .clock_o(sclk_w));

  // *****
  // compare, bus and pin tasks
  // *****
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk8(reg_rdata_o, exp, what);
  endtask : rd
  // bounded wait for a dispatch, then compare the entry field
  task automatic wait_entry(input logic [7:0] exp, input string what);
    for (int n = 0; n < 300 && instr_addr_o[11:4] !== exp; n++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk8(instr_addr_o[11:4], exp, what);
  endtask : wait_entry
  task automatic set_pin(input int n, input logic v);
    @(posedge clk_sys_i);
    case (n)
      0: sthp_host_mcu_inst.level(v, 1'b1);
      1: sthp_host_mcu_inst.level(1'b1, v);
      2: trigger_pin_five_i <= v;
      default: trigger_pin_six_i <= v;
    endcase
  endtask : set_pin
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // *****
  // test sequence
  // *****
  initial begin
    int t0;
    int n;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t0 = cyc;
    for (int k = 0; k < 9; k++) rd(RA[k], RV[k], "reset value");
    chk1(stop_a_or_busy_out_o, 1'b1, "stop bit on shared pin");
    wait_entry(8'h20, "power-on vector");
    chk1(cyc - t0 >= POI_T, 1'b1, "power-on delay");
    n = 0;
    while (instr_addr_o[3:0] === 4'h0 && n < 40) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    chk8(8'(n), 8'(INSTR_T), "instruction spacing");
    repeat (30) @(posedge clk_sys_i);
    rd(REG_MODE_CFG_FIRST, 8'heb, "mode load");
    rd(REG_EN0, 8'h00, "enable load");
    chk1(stop_a_or_busy_out_o, 1'b0, "busy on shared pin");
    chk1(play_halt_o, 1'b0, "no halt outside host mode");
    chk8(8'(instr_addr_o[PC_W-1:12]), 8'h00, "page bits after reset");
    rd(REG_STAT, 8'h00, "status idle");
    $display("test power-on done");
    wr(REG_EN0, 8'h33);
    for (int k = 0; k < 4; k++) begin
      set_pin(k, 1'b0);
      wait_entry(FALL[k], "fall vector");
      set_pin(k, 1'b1);
      wait_entry(RISE[k], "rise vector");
    end
    // both pins at once: pin five must win
    @(posedge clk_sys_i);
    trigger_pin_five_i <= 1'b0;
    trigger_pin_six_i <= 1'b0;
    wait_entry(8'h08, "fall priority");
    @(posedge clk_sys_i);
    trigger_pin_five_i <= 1'b1;
    trigger_pin_six_i <= 1'b1;
    wait_entry(8'h0c, "rise priority");
    wr(REG_EN1, 8'h00);
    set_pin(2, 1'b0);
    repeat (60) @(posedge clk_sys_i);
    #1 chk8(instr_addr_o[11:4], 8'h0c, "disabled edge");
    set_pin(2, 1'b1);
    $display("test triggers done");
    wr(REG_EN0, 8'h00);
    host_mode_i <= 1'b1;
    play_busy_i <= 1'b1;
    sthp_host_mcu_inst.send_bits(8'h22);
    chk1(play_halt_o, 1'b1, "halt while receiving");
    repeat (20) @(posedge clk_sys_i);
    #1 chk1(stop_a_or_busy_out_o, 1'b0, "busy waits for data high");
    sthp_host_mcu_inst.release_data();
    repeat (6) @(posedge clk_sys_i);
    #1 chk1(stop_a_or_busy_out_o, 1'b1, "busy after data high");
    wait_entry(8'h22, "host vector");
    rd(REG_RXB, 8'h22, "received byte");
    repeat (60) @(posedge clk_sys_i);
    #1 chk1(stop_a_or_busy_out_o, 1'b1, "busy while playing");
    rd(REG_STAT, 8'h01, "status busy while playing");
    rd(REG_R0, 8'h21, "conditional increments");
    @(posedge clk_sys_i);
    play_busy_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 chk1(stop_a_or_busy_out_o, 1'b0, "busy drops after play");
    $display("test host byte done");
    sthp_host_mcu_inst.send_bits(8'ha5);
    repeat (6) @(posedge clk_sys_i);
    #1 chk1(stop_a_or_busy_out_o, 1'b1, "busy after last clock");
    sthp_host_mcu_inst.release_data();
    wait_entry(8'ha5, "second host vector");
    rd(REG_RXB, 8'ha5, "second byte");
    $display("test second host byte done");
    results();
  end

  // watchdog: the whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end
endmodule : tb_sthp_ctrl
`default_nettype wire
